// [sfcc_pkg.sv]
// Shared constants and types for the serial flash command sequencer
`default_nettype none
package sfcc_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_SEC_RD = 8'h48;
  localparam logic [7:0] OP_WRAP_RD = 8'h0C;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_SUS = 8'h75;
  localparam logic [7:0] OP_RES = 8'h7A;
  localparam logic [7:0] OP_DPD = 8'hB9;
  localparam logic [7:0] OP_RDI = 8'hAB;
  localparam logic [7:0] OP_RDPAR = 8'hC0;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_SEC_PG = 8'h42;
  localparam logic [7:0] OP_SEC_ER = 8'h44;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE1 = 8'hC7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  // ****************************************
  // Frame layout in link clock edges, address windows and drive enables
  // ****************************************
  localparam logic [7:0] SPI_OPC_CYC = 8'h08;
  localparam logic [7:0] QPI_OPC_CYC = 8'h02;
  localparam logic [7:0] SPI_ADDR_END = 8'h20;
  localparam logic [7:0] QPI_ADDR_END = 8'h08;
  localparam logic [7:0] SPI_SEC_DATA = 8'h28;
  localparam logic [7:0] SPI_ID_START = 8'h20;
  localparam logic [7:0] QPI_ID_START = 8'h08;
  localparam logic [7:0] WRAP_DUM_BASE = 8'h04;
  localparam logic [23:0] WRAP_MIN_LEN = 24'h000008;
  localparam logic [9:0] SEC_LAST = 10'h3FF;
  localparam logic [3:0] OE_SPI = 4'h2;
  localparam logic [3:0] OE_QPI = 4'hF;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int T_RST_NS = 30000;
  localparam int T_DP_NS = 3000;
  localparam int T_RES1_NS = 8000;
  localparam int T_RES2_NS = 12000;
  localparam int T_SUS_NS = 20000;
  localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int DP_CYC = (T_DP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RES1_CYC = (T_RES1_NS + CLK_NS - 1) / CLK_NS;
  localparam int RES2_CYC = (T_RES2_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUS_CYC = T_SUS_NS / CLK_NS;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {K_NONE, K_SEC, K_WRAP, K_ID} sfcc_kind_t;
  typedef enum logic [1:0] {REC_IDLE, REC_RESET, REC_DPD, REC_REL} sfcc_rec_t;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] cyc;
    logic [7:0] arg;
    logic       quad;
  } sfcc_frame_t;
  typedef struct packed {logic valid; logic [7:0] op;} sfcc_cmd_t;
  typedef struct packed {logic write_in_progress; logic esus; logic psus; logic write_enable_latch; logic dpd;} sfcc_stat_t;
  typedef struct packed {logic blk; logic write_in_progress; logic [7:0] par;} sfcc_lnk_t;
endpackage : sfcc_pkg
`default_nettype wire

// [sfcc_top.sv]
// Command sequencer of a serial flash: link decode, suspend, reset, power-down
`default_nettype none
module sfcc_top #(
  parameter logic [7:0] DEV_ID = 8'h5A // Arbitrary identification value
) (
  // System side
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Flash link
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic [3:0]           io_i,
  output logic [3:0]                io_o,
  output logic [3:0]                io_oe,
  input  wire logic                 qpi_i,
  // Array read port, link domain
  output logic [23:0]               rd_addr_o,
  input  wire logic [7:0]           rd_byte_i,
  // Array engine, system domain
  input  wire logic                 pe_start_i,
  input  wire logic                 pe_erase_i,
  input  wire logic                 pe_done_i,
  output logic                      pe_pause_o,
  output logic                      sw_reset_o,
  output sfcc_pkg::sfcc_cmd_t       cmd_o,
  output sfcc_pkg::sfcc_stat_t      stat_o,
  output logic [7:0]                param_o
);
  // ****************************************
  // Link domain: frame capture
  // ****************************************
  logic                  link_clr;
  logic                  frame_on_r;
  logic [7:0]            cyc_r;
  logic [31:0]           sh_r;
  logic [7:0]            op_r;
  logic                  quad_r;
  logic [23:0]           addr_r;
  sfcc_pkg::sfcc_kind_t  kind_r;
  logic [2:0]            dbit_r;
  logic                  qpi_s1_r;
  logic                  qpi_s2_r;
  sfcc_pkg::sfcc_lnk_t   lnk_r;
  sfcc_pkg::sfcc_lnk_t   lnk_s1_r;
  sfcc_pkg::sfcc_lnk_t   lnk_s2_r;
  logic [7:0]            e;
  logic                  quad;
  logic [31:0]           sh_nxt;
  logic [7:0]            op_nxt;
  logic [7:0]            dum;
  logic [23:0]           wmask;
  logic                  step;
  logic                  go_sec;
  logic                  go_wrap;
  logic                  go_id;
  logic                  ld_addr;
  logic [23:0]           addr_nxt;
  logic [7:0]            out_byte;

  // Frame state ends with the frame itself, so chip select clears it
  assign link_clr = cs_n | ~rst_b;
  assign e        = frame_on_r ? cyc_r : 8'h00;
  assign quad     = frame_on_r ? quad_r : qpi_s2_r;
  assign sh_nxt   = quad ? {sh_r[27:0], io_i} : {sh_r[30:0], io_i[0]};
  assign op_nxt   = sh_nxt[7:0];
  assign dum      = {5'h00, lnk_s2_r.par[5:4], 1'b0} + sfcc_pkg::WRAP_DUM_BASE;
  assign wmask    = (sfcc_pkg::WRAP_MIN_LEN << lnk_s2_r.par[1:0]) - 24'h000001;
  assign step     = quad ? dbit_r[0] : (dbit_r == 3'h7);
  assign ld_addr  = quad ? (e == sfcc_pkg::QPI_ADDR_END - 8'h01)
                         : (e == sfcc_pkg::SPI_ADDR_END - 8'h01);
  assign go_sec   = ~quad && op_r == sfcc_pkg::OP_SEC_RD && ~lnk_s2_r.blk
                    && e == sfcc_pkg::SPI_SEC_DATA - 8'h01;
  assign go_wrap  = quad && op_r == sfcc_pkg::OP_WRAP_RD && ~lnk_s2_r.blk
                    && e == sfcc_pkg::QPI_ADDR_END + dum - 8'h01;
  assign go_id    = op_r == sfcc_pkg::OP_RDI && ~lnk_s2_r.blk && ~lnk_s2_r.write_in_progress
                    && e == (quad ? sfcc_pkg::QPI_ID_START : sfcc_pkg::SPI_ID_START) - 8'h01;
  assign addr_nxt = ld_addr ? sh_nxt[23:0]
                  : (kind_r == sfcc_pkg::K_SEC && step)
                    ? {addr_r[23:10], addr_r[9:0] + 10'h001}
                  : (kind_r == sfcc_pkg::K_WRAP && step)
                    ? ((addr_r & ~wmask) | ((addr_r + 24'h000001) & wmask))
                  : addr_r;
  assign out_byte = (kind_r == sfcc_pkg::K_ID) ? DEV_ID : rd_byte_i;
  assign rd_addr_o = addr_r;

  // Level crossings into the link domain; the mode is used at frame start, the link status within frames
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      qpi_s1_r <= 1'b0;
      qpi_s2_r <= 1'b0;
      lnk_s1_r <= '0;
      lnk_s2_r <= '0;
    end else begin
      qpi_s1_r <= qpi_i;
      qpi_s2_r <= qpi_s1_r;
      lnk_s1_r <= lnk_r;
      lnk_s2_r <= lnk_s1_r;
    end
  end

  // Held past chip select rise so the system domain can read them
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      sh_r   <= '0;
      op_r   <= '0;
      quad_r <= 1'b0;
      addr_r <= '0;
      cyc_r  <= '0;
    end else begin
      sh_r   <= sh_nxt;
      op_r   <= (e == (quad ? sfcc_pkg::QPI_OPC_CYC : sfcc_pkg::SPI_OPC_CYC) - 8'h01)
                ? op_nxt : op_r;
      quad_r <= quad;
      addr_r <= addr_nxt;
      cyc_r  <= (e == 8'hFF) ? e : e + 8'h01;
    end
  end

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      frame_on_r <= 1'b0;
      kind_r     <= sfcc_pkg::K_NONE;
      dbit_r     <= '0;
    end else begin
      frame_on_r <= 1'b1;
      kind_r     <= go_sec ? sfcc_pkg::K_SEC : go_wrap ? sfcc_pkg::K_WRAP
                  : go_id ? sfcc_pkg::K_ID : kind_r;
      dbit_r     <= (kind_r == sfcc_pkg::K_NONE) ? 3'h0 : dbit_r + 3'h1;
    end
  end

  // Data leaves on the falling edge, most significant bit or nibble first
  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      io_o  <= '0;
      io_oe <= '0;
    end else if (kind_r == sfcc_pkg::K_NONE) begin
      io_o  <= '0;
      io_oe <= '0;
    end else if (quad_r) begin
      io_o  <= dbit_r[0] ? out_byte[3:0] : out_byte[7:4];
      io_oe <= sfcc_pkg::OE_QPI;
    end else begin
      io_o  <= {2'b00, out_byte[3'h7 - dbit_r], 1'b0};
      io_oe <= sfcc_pkg::OE_SPI;
    end
  end

  // ****************************************
  // System domain: frame end decode
  // ****************************************
  logic                  cs_s1_r;
  logic                  cs_s2_r;
  logic                  cs_s3_r;
  sfcc_pkg::sfcc_frame_t fr;
  sfcc_pkg::sfcc_rec_t   rec_r;
  logic [11:0]           rec_cnt_r;
  logic [11:0]           sus_cnt_r;
  logic                  rst_en_r;
  logic                  pe_erase_r;
  logic                  fend;
  logic [7:0]            opc;
  logic                  full;
  logic                  exact;
  logic                  busy;
  logic                  take;
  logic                  acc_rst;
  logic                  acc_sus;
  logic                  acc_res;
  logic                  acc_dpd;
  logic                  acc_rel;
  logic                  acc_par;
  logic                  er_op;
  logic                  esus_bar;
  logic                  psus_bar;
  logic                  internal;
  logic                  fwd;
  logic                  rec_done;
  logic                  sus_clr;

  assign fr       = '{op: op_r, cyc: cyc_r, arg: sh_r[7:0], quad: quad_r};
  assign fend     = cs_s2_r & ~cs_s3_r;
  assign opc      = fr.quad ? sfcc_pkg::QPI_OPC_CYC : sfcc_pkg::SPI_OPC_CYC;
  assign full     = fr.cyc >= opc;
  assign exact    = fr.cyc == opc;
  assign busy     = rec_r != sfcc_pkg::REC_IDLE;
  assign take     = fend && full && ~busy
                    && (~stat_o.dpd || fr.op == sfcc_pkg::OP_RDI
                        || fr.op == sfcc_pkg::OP_RST_EN || fr.op == sfcc_pkg::OP_RST);
  assign acc_rst  = take && fr.op == sfcc_pkg::OP_RST && rst_en_r;
  assign acc_sus  = take && ~stat_o.dpd && fr.op == sfcc_pkg::OP_SUS && stat_o.write_in_progress
                    && ~stat_o.esus && ~stat_o.psus;
  assign acc_res  = take && ~stat_o.dpd && fr.op == sfcc_pkg::OP_RES && ~stat_o.write_in_progress
                    && (stat_o.esus || stat_o.psus);
  assign acc_dpd  = take && fr.op == sfcc_pkg::OP_DPD && exact && ~stat_o.write_in_progress
                    && ~stat_o.dpd;
  assign acc_rel  = take && fr.op == sfcc_pkg::OP_RDI && stat_o.dpd && ~stat_o.write_in_progress;
  assign acc_par  = take && ~stat_o.dpd && fr.op == sfcc_pkg::OP_RDPAR
                    && fr.cyc == {opc[6:0], 1'b0};
  assign er_op    = fr.op == sfcc_pkg::OP_SEC_ER || fr.op == sfcc_pkg::OP_SE
                    || fr.op == sfcc_pkg::OP_BE32 || fr.op == sfcc_pkg::OP_BE64
                    || fr.op == sfcc_pkg::OP_CE1 || fr.op == sfcc_pkg::OP_CE2;
  assign esus_bar = er_op || fr.op == sfcc_pkg::OP_WRSR;
  assign psus_bar = esus_bar || fr.op == sfcc_pkg::OP_SEC_PG
                    || fr.op == sfcc_pkg::OP_PP || fr.op == sfcc_pkg::OP_QPP;
  assign internal = fr.op == sfcc_pkg::OP_RST_EN || fr.op == sfcc_pkg::OP_RST
                    || fr.op == sfcc_pkg::OP_SUS || fr.op == sfcc_pkg::OP_RES
                    || fr.op == sfcc_pkg::OP_DPD || fr.op == sfcc_pkg::OP_RDI
                    || fr.op == sfcc_pkg::OP_RDPAR;
  assign fwd      = take && ~stat_o.dpd && ~internal
                    && ~(stat_o.psus && psus_bar) && ~(stat_o.esus && esus_bar);
  assign rec_done = busy && rec_cnt_r == 12'h001;
  assign sus_clr  = sus_cnt_r == 12'h001;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  // ****************************************
  // System domain: status and recovery
  // ****************************************
  // Reset aborts everything, so it outranks every set in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_o     <= '0;
      rst_en_r   <= 1'b0;
      pe_erase_r <= 1'b0;
      pe_pause_o <= 1'b0;
      sus_cnt_r  <= '0;
      param_o    <= '0;
    end else if (acc_rst) begin
      stat_o     <= '0;
      rst_en_r   <= 1'b0;
      pe_erase_r <= 1'b0;
      pe_pause_o <= 1'b0;
      sus_cnt_r  <= '0;
      param_o    <= '0;
    end else begin
      stat_o.write_in_progress  <= (pe_start_i || acc_res) ? 1'b1
                   : (pe_done_i || sus_clr) ? 1'b0 : stat_o.write_in_progress;
      stat_o.esus <= acc_res ? 1'b0 : (acc_sus && pe_erase_r) ? 1'b1 : stat_o.esus;
      stat_o.psus <= acc_res ? 1'b0 : (acc_sus && ~pe_erase_r) ? 1'b1 : stat_o.psus;
      stat_o.write_enable_latch  <= (fwd && fr.op == sfcc_pkg::OP_WREN) ? 1'b1
                   : pe_done_i ? 1'b0 : stat_o.write_enable_latch;
      stat_o.dpd  <= (rec_done && rec_r == sfcc_pkg::REC_DPD) ? 1'b1
                   : (rec_done && rec_r == sfcc_pkg::REC_REL) ? 1'b0 : stat_o.dpd;
      rst_en_r    <= (fend && full) ? (fr.op == sfcc_pkg::OP_RST_EN && ~busy) : rst_en_r;
      pe_erase_r  <= pe_start_i ? pe_erase_i : pe_erase_r;
      pe_pause_o  <= acc_res ? 1'b0 : acc_sus ? 1'b1 : pe_pause_o;
      sus_cnt_r   <= acc_sus ? 12'(sfcc_pkg::SUS_CYC)
                   : (sus_cnt_r != 12'h000) ? sus_cnt_r - 12'h001 : sus_cnt_r;
      param_o     <= acc_par ? fr.arg : param_o;
    end
  end

  // Long waits counted here so the link never sees a half-done transition
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rec_r     <= sfcc_pkg::REC_IDLE;
      rec_cnt_r <= '0;
    end else begin
      case (rec_r)
        sfcc_pkg::REC_IDLE: begin
          if (acc_rst) begin
            rec_r     <= sfcc_pkg::REC_RESET;
            rec_cnt_r <= 12'(sfcc_pkg::RST_CYC);
          end else if (acc_dpd) begin
            rec_r     <= sfcc_pkg::REC_DPD;
            rec_cnt_r <= 12'(sfcc_pkg::DP_CYC);
          end else if (acc_rel) begin
            rec_r     <= sfcc_pkg::REC_REL;
            rec_cnt_r <= exact ? 12'(sfcc_pkg::RES1_CYC) : 12'(sfcc_pkg::RES2_CYC);
          end
        end
        sfcc_pkg::REC_RESET, sfcc_pkg::REC_DPD, sfcc_pkg::REC_REL: begin
          rec_cnt_r <= rec_cnt_r - 12'h001;
          if (rec_done) begin
            rec_r <= sfcc_pkg::REC_IDLE;
          end
        end
        default: begin
          rec_r <= sfcc_pkg::REC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_o      <= '0;
      sw_reset_o <= 1'b0;
      lnk_r      <= '0;
    end else begin
      cmd_o      <= '{valid: fwd, op: fr.op};
      sw_reset_o <= acc_rst;
      lnk_r      <= '{blk: busy || stat_o.dpd, write_in_progress: stat_o.write_in_progress, par: param_o};
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sec_incr_a: assert property (@(posedge sclk) disable iff (link_clr)
    (kind_r == sfcc_pkg::K_SEC && step && addr_r[9:0] != sfcc_pkg::SEC_LAST)
      |=> addr_r[9:0] == $past(addr_r[9:0]) + 10'h001)
    else $error("security read address did not advance");
  sec_wrap_a: assert property (@(posedge sclk) disable iff (link_clr)
    (kind_r == sfcc_pkg::K_SEC && step && addr_r[9:0] == sfcc_pkg::SEC_LAST)
      |=> addr_r[9:0] == 10'h000 && addr_r[23:10] == $past(addr_r[23:10]))
    else $error("security read address did not wrap to zero");
  wrap_win_a: assert property (@(posedge sclk) disable iff (link_clr)
    (kind_r == sfcc_pkg::K_WRAP && step)
      |=> (addr_r & ~wmask) == $past(addr_r & ~wmask))
    else $error("wrapped read left its window");
  rst_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    acc_rst |=> stat_o == '0 && param_o == 8'h00 && sw_reset_o && !pe_pause_o)
    else $error("reset left volatile state set");
  rst_block_a: assert property (@(posedge clk) disable iff (!rst_b)
    acc_rst |=> (rec_r == sfcc_pkg::REC_RESET && !cmd_o.valid)[*8])
    else $error("command taken during reset recovery");
  sus_take_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fend && fr.op == sfcc_pkg::OP_SUS && (!stat_o.write_in_progress || stat_o.esus || stat_o.psus))
      |=> $stable(stat_o.esus) && $stable(stat_o.psus))
    else $error("suspend taken in wrong state");
  sus_lat_a: assert property (@(posedge clk) disable iff (!rst_b)
    acc_sus |=> (stat_o.esus || stat_o.psus) ##[0:500] !stat_o.write_in_progress)
    else $error("suspend latency exceeded");
  res_take_a: assert property (@(posedge clk) disable iff (!rst_b)
    acc_res |=> !stat_o.esus && !stat_o.psus && stat_o.write_in_progress && !pe_pause_o)
    else $error("resume did not restart the cycle");
  sus_reject_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fend && ((stat_o.psus && psus_bar) || (stat_o.esus && esus_bar))) |=> !cmd_o.valid)
    else $error("forbidden command passed while suspended");
  dpd_only_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fend && stat_o.dpd) |=> !cmd_o.valid)
    else $error("command passed in deep power-down");
  dpd_wip_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fend && stat_o.write_in_progress && !stat_o.dpd) |=> rec_r != sfcc_pkg::REC_DPD)
    else $error("power-down taken while busy");
  rdi_wip_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fend && stat_o.write_in_progress) |=> rec_r != sfcc_pkg::REC_REL)
    else $error("release taken while busy");
  short_frame_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fend && !full) |=> !cmd_o.valid && $stable(stat_o) && $stable(rst_en_r))
    else $error("short frame changed state");
endmodule : sfcc_top
`default_nettype wire

// [sfcc_host.sv]
// Host link model that sends command frames to the flash
`default_nettype none
module sfcc_host (
  // Flash link
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      io_i,
  input  wire logic [3:0] io_o,
  input  wire logic       qpi_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    io_i = 4'h0;
  end
  // Link clock runs only within frames, 12 ns period
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    logic [31:0] sh;
    sh = tx;
    rx = '0;
    cs_n = 1'h0;
    for (int i = 0; i < n; i++) begin
      io_i = qpi_i ? sh[31:28] : {3'h0, sh[31]};
      sh = qpi_i ? {sh[27:0], ~sh[31:28]} : {sh[30:0], ~sh[31]};
      #6 sclk = 1'h1;
      rx = {rx[30:0], io_o[1]};
      #6 sclk = 1'h0;
    end
    #6 cs_n = 1'h1;
    // Released data lines must not keep the last value
    io_i = ~io_i;
    #300;
  endtask : xfer
endmodule : sfcc_host
`default_nettype wire

// [sfcc_top_bench.sv]
// Self-checking bench for the flash command sequencer
`default_nettype none
module sfcc_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ID = 8'h5A; // Arbitrary identification value
  logic                 clk, rst_b, qpi_i, pe_start_i, pe_erase_i, pe_done_i;
  logic                 sclk, cs_n, pe_pause_o, sw_reset_o;
  logic [3:0]           io_i, io_o, io_oe, oe_seen;
  logic [23:0]          rd_addr_o, a;
  logic [7:0]           rd_byte_i, param_o, p, lastop;
  logic [31:0]          rx;
  sfcc_pkg::sfcc_cmd_t  cmd_o;
  sfcc_pkg::sfcc_stat_t stat_o;
  int                   num_errors, samples_checked, ncmd, nrst, n;
  always #20 clk = ~clk;
  function automatic logic [7:0] mem(input logic [23:0] ad);
    return ad[7:0] ^ {ad[9:8], 6'h15};
  endfunction : mem
  // Address after k steps inside the window that the read parameters choose
  function automatic logic [23:0] wrap(input logic [23:0] ad, input logic [7:0] pr, input int k);
    logic [23:0] m;
    m = (sfcc_pkg::WRAP_MIN_LEN << pr[1:0]) - 24'h000001;
    return (ad & ~m) | ((ad + 24'(k)) & m);
  endfunction : wrap
  assign rd_byte_i = mem(rd_addr_o);
  always @(posedge clk) begin
    if (cmd_o.valid === 1'h1) begin
      ncmd++;
      lastop = cmd_o.op;
    end
    if (sw_reset_o === 1'h1) nrst++;
  end
  // Enables seen while selected, gathered to check the drive width
  always @(posedge sclk) begin
    if (cs_n === 1'h0) oe_seen = oe_seen | io_oe;
  end
  sfcc_top #(.DEV_ID(ID)) uut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n),
    .io_i(io_i), .io_o(io_o), .io_oe(io_oe), .qpi_i(qpi_i), .rd_addr_o(rd_addr_o),
    .rd_byte_i(rd_byte_i), .pe_start_i(pe_start_i), .pe_erase_i(pe_erase_i),
    .pe_done_i(pe_done_i), .pe_pause_o(pe_pause_o), .sw_reset_o(sw_reset_o),
    .cmd_o(cmd_o), .stat_o(stat_o), .param_o(param_o));
  sfcc_host host (.sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .qpi_i(qpi_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc
  task automatic op(input logic [7:0] o, input int e = 8);
    host.xfer({o, 24'h0}, e, rx);
  endtask : op
  // Framing reaches the link only on link clock edges, so a frame that
  // the flash discards carries a new setting across before it is used
  task automatic mode(input logic q);
    qpi_i = q;
    host.xfer(32'h0, 2, rx);
  endtask : mode
  // Start (1) or finish (0) an array cycle, one clock wide
  task automatic pulse(input logic st, input logic er);
    cyc(1);
    pe_erase_i = er;
    pe_start_i = st;
    pe_done_i = ~st;
    cyc(1);
    pe_start_i = 1'h0;
    pe_done_i = 1'h0;
    cyc(2);
  endtask : pulse
  task automatic conclude;
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    #1ms;
    num_errors++;
    conclude();
  end
  initial begin
    {clk, rst_b, qpi_i, pe_start_i, pe_erase_i, pe_done_i} = '0;
    rx = $urandom(32'h0730);
    cyc(20);
    rst_b = 1'h1;
    cyc(3);
    chk(stat_o, 0, "status after reset");
    op(sfcc_pkg::OP_WREN, 7);
    chk(stat_o.write_enable_latch, 0, "short frame acted");
    op(sfcc_pkg::OP_WREN);
    chk(stat_o.write_enable_latch, 1, "write enable");
    $display("test power-up done");
    for (int k = 0; k < 4; k++) begin
      a = {14'h0004, 10'($urandom)};
      if (k == 0) a[9:0] = sfcc_pkg::SEC_LAST;
      host.xfer({sfcc_pkg::OP_SEC_RD, a}, 56, rx);
      chk(rx[15:0], {mem(a), mem({a[23:10], a[9:0] + 10'h001})}, "security read");
    end
    oe_seen = '0;
    host.xfer({sfcc_pkg::OP_RDI, 24'h0}, 48, rx);
    chk(rx[15:0], {ID, ID}, "device id");
    chk(oe_seen, sfcc_pkg::OE_SPI, "id drive width");
    $display("test reads done");
    pulse(1'h1, 1'h0);
    chk(stat_o.write_in_progress, 1, "busy during program");
    op(sfcc_pkg::OP_DPD);
    cyc(sfcc_pkg::DP_CYC + 10);
    chk(stat_o.dpd, 0, "power-down while busy");
    op(sfcc_pkg::OP_RDI);
    chk(stat_o.write_in_progress, 1, "release while busy");
    op(sfcc_pkg::OP_SUS);
    chk({stat_o.psus, pe_pause_o}, 2'h3, "suspend flag");
    cyc(sfcc_pkg::SUS_CYC + 10);
    chk(stat_o.write_in_progress, 0, "busy after suspend");
    n = ncmd;
    op(sfcc_pkg::OP_PP);
    op(sfcc_pkg::OP_WRSR);
    chk(ncmd, n, "program suspend filter");
    op(sfcc_pkg::OP_SUS);
    chk({stat_o.psus, stat_o.write_in_progress}, 2'h2, "second suspend");
    op(sfcc_pkg::OP_RES);
    chk({stat_o.psus, stat_o.write_in_progress, pe_pause_o}, 3'h2, "resume");
    pulse(1'h0, 1'h0);
    chk(stat_o.write_in_progress, 0, "program done");
    op(sfcc_pkg::OP_RES);
    op(sfcc_pkg::OP_SUS);
    chk({stat_o.write_in_progress, stat_o.psus}, 0, "idle resume or suspend");
    $display("test program suspend done");
    pulse(1'h1, 1'h1);
    op(sfcc_pkg::OP_SUS);
    chk(stat_o.esus, 1, "erase suspend");
    cyc(sfcc_pkg::SUS_CYC + 10);
    n = ncmd;
    op(sfcc_pkg::OP_BE64);
    op(sfcc_pkg::OP_SEC_ER);
    op(sfcc_pkg::OP_QPP);
    chk(ncmd, n + 1, "erase suspend filter");
    chk(lastop, sfcc_pkg::OP_QPP, "forwarded opcode");
    p = 8'($urandom);
    host.xfer({sfcc_pkg::OP_RDPAR, p, 16'h0}, 16, rx);
    chk(param_o, p, "read parameters");
    mode(1'h1);
    a = 24'($urandom);
    n = 12;
    oe_seen = '0;
    host.xfer({sfcc_pkg::OP_WRAP_RD, a}, 12 + 2 * p[5:4] + 2 * n, rx);
    chk(rd_addr_o, wrap(a, p, n), "wrap address");
    chk(oe_seen, sfcc_pkg::OE_QPI, "wrap drive width");
    a = wrap(a, p, n - 1);
    p = mem(a);
    chk(rx[1:0], {p[5], p[1]}, "wrap data");
    // Status was read above before resetting in quad framing
    op(sfcc_pkg::OP_RST_EN, 2);
    op(sfcc_pkg::OP_RST, 2);
    mode(1'h0);
    chk(nrst, 1, "reset pulse");
    chk({stat_o, param_o}, 0, "state after reset");
    op(sfcc_pkg::OP_WREN);
    chk(stat_o.write_enable_latch, 0, "command in recovery");
    cyc(sfcc_pkg::RST_CYC);
    op(sfcc_pkg::OP_WREN);
    chk(stat_o.write_enable_latch, 1, "command after recovery");
    $display("test reset done");
    op(sfcc_pkg::OP_DPD);
    cyc(sfcc_pkg::DP_CYC + 10);
    chk(stat_o.dpd, 1, "power-down entry");
    host.xfer({sfcc_pkg::OP_RDPAR, 8'h33, 16'h0}, 16, rx);
    chk(param_o, 0, "command in power-down");
    op(sfcc_pkg::OP_RDI);
    cyc(sfcc_pkg::RES1_CYC + 10);
    chk(stat_o.dpd, 0, "release");
    op(sfcc_pkg::OP_DPD);
    cyc(sfcc_pkg::DP_CYC + 10);
    host.xfer({sfcc_pkg::OP_RDI, 24'h0}, 48, rx);
    cyc(sfcc_pkg::RES1_CYC + 10);
    chk(stat_o.dpd, 1, "release with id still waiting");
    cyc(sfcc_pkg::RES2_CYC - sfcc_pkg::RES1_CYC);
    chk(stat_o.dpd, 0, "release with id");
    $display("test power-down done");
    conclude();
  end
endmodule : sfcc_top_bench
`default_nettype wire
